// ===== dsc_defs.svh
// Constants of the dual switch serial control and diagnosis block
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define DSC_CLK_NS        40
`define DSC_FILTER_NS     10000
`define DSC_WAKE_NS       100000

// ****************************************
// Frame layout
// ****************************************
`define DSC_CMD_HI        7
`define DSC_CMD_LO        5
`define DSC_RX_LAST       4'h7
`define DSC_RX_OVER       4'h8
`define DSC_RX_SAT        4'h9
`define DSC_TX_MSB        3'h7

// ****************************************
// Command codes
// ****************************************
`define DSC_CMD_NOP       3'h0
`define DSC_CMD_DIAG      3'h1
`define DSC_CMD_OUTCFG    3'h2
`define DSC_CMD_IOCFG     3'h3
`define DSC_CMD_RESET     3'h4
`define DSC_CMD_SLEEP     3'h5
`define DSC_CMD_WAKE      3'h6
`define DSC_CMD_CHON      3'h7

// ****************************************
// Data bit positions
// ****************************************
`define DSC_D_OVL2        4
`define DSC_D_OVL1        3
`define DSC_D_OTLATCH     2
`define DSC_D_SLEW2       1
`define DSC_D_SLEW1       0
`define DSC_D_IOSPI       4
`define DSC_D_SRC_HI      3
`define DSC_D_SRC_LO      2
`define DSC_D_MF_HI       1
`define DSC_D_MF_LO       0
`define DSC_D_CH2         4
`define DSC_D_CH1         3

// ****************************************
// Field values and reset values
// ****************************************
`define DSC_CODE_OK       2'h3
`define DSC_CODE_OVL      2'h2
`define DSC_CODE_OPEN     2'h1
`define DSC_CODE_SHORT    2'h0
`define DSC_DIAG_UNUSED   2'h3
`define DSC_DIAG_RST      8'hFC
`define DSC_SRC_PAR       2'h0
`define DSC_SRC_OR        2'h1
`define DSC_SRC_AND       2'h2
`define DSC_MF_FAULT      2'h0
`define DSC_CS_SYNC_RST   4'hF

`endif

// ===== dsc_pkg.sv
// Types of the dual switch serial control and diagnosis block
package dsc_pkg;
  typedef enum logic [2:0] {
    mode_active = 3'b001,
    mode_sleep  = 3'b010,
    mode_waking = 3'b100
  } dsc_mode_t;
endpackage

// ===== dsc_spi_diag.sv
// Serial control and diagnosis logic of a dual low-side switch
`timescale 1ns/100ps
`include "dsc_defs.svh"

module dsc_spi_diag #(
  parameter int FILTER_NS = `DSC_FILTER_NS,  // Fault filter time in ns
  parameter int WAKE_NS   = `DSC_WAKE_NS     // Wake settle time in ns
) (
  input  wire logic              core_clk_i,           // Core clock, 25 MHz
  input  wire logic              arst_n_i,             // Async reset, low active
  input  wire logic              sclk_i,               // Serial clock from host
  input  wire logic              cs_n_i,               // Chip select, low active
  input  wire logic              si_i,                 // Serial data in
  output logic                   so_o,                 // Serial data out
  output logic                   so_oe_o,              // Serial out enable
  input  wire logic              parallel_in_ch1_i,    // Parallel control ch1
  input  wire logic              parallel_in_ch2_i,    // Parallel control ch2
  input  wire logic              uv_rst_i,             // Undervoltage reset
  input  wire logic [1:0]        short_gnd_i,          // Short to ground per channel
  input  wire logic [1:0]        open_load_i,          // Open load or undercurrent
  input  wire logic [1:0]        overload_i,           // Current limiting active
  input  wire logic [1:0]        ch_overtemp_i,        // Channel overtemperature
  input  wire logic              ic_overtemp_i,        // Die overheat warning
  output logic [1:0]             ch_on_o,              // Channel drive request
  output logic                   overload_mode_ch1_o,  // 1: limiting, 0: shutoff
  output logic                   overload_mode_ch2_o,  // 1: limiting, 0: shutoff
  output logic                   ot_latch_o,           // 1: latch off on overtemp
  output logic [1:0]             slow_slew_o,          // 1: slow switching
  output logic                   spi_diag_mode_o,      // 1: serial out and fault pin
  output logic [1:0]             ctrl_src_o,           // Channel control source
  output logic [1:0]             mf_sel_o,             // Multifunction pin role
  output logic                   fault_flag_n_o,       // General fault, low active
  output logic                   sense_fault_pin_oe_o, // Open drain pull low
  output dsc_pkg::dsc_mode_t     mode_o,               // Power mode
  output logic                   ready_o               // Fully functional
);
  import dsc_pkg::*;

  // ****************************************
  // Derived counts and checks
  // ****************************************
  localparam int FILT_CYC = (FILTER_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS;
  localparam int WAKE_CYC = (WAKE_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS;
  localparam int FILT_W   = $clog2(FILT_CYC + 1);
  localparam int WAKE_W   = $clog2(WAKE_CYC + 1);

  if (FILTER_NS < 1 || WAKE_NS < 1) begin : g_chk
    $error("Filter and wake times must be positive");
  end

  // ****************************************
  // Link side, serial clock domain
  // ****************************************
  logic [3:0] rx_cnt;
  logic [6:0] rx_sh;
  logic [7:0] frame_word;
  logic       frm_tgl;
  logic       ovr_tgl;
  logic [2:0] tx_cnt;
  logic [7:0] shadow;
  logic       spi_mode;
  wire        rx_rst_n = arst_n_i & ~cs_n_i;  // Select high holds the link idle

  // Input sampled on falling edge; select high clears the bit count
  always_ff @(negedge sclk_i or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      rx_cnt <= 4'h0;
      rx_sh  <= 7'h00;
    end else begin
      rx_sh <= {rx_sh[5:0], si_i};
      if (rx_cnt != `DSC_RX_SAT) begin
        rx_cnt <= rx_cnt + 4'h1;
      end
    end
  end

  // Eighth bit completes a frame, a ninth marks it overlong
  always_ff @(negedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_word <= 8'h00;
      frm_tgl    <= 1'b0;
      ovr_tgl    <= 1'b0;
    end else begin
      if (rx_cnt == `DSC_RX_LAST) begin
        frame_word <= {rx_sh, si_i};
        frm_tgl    <= ~frm_tgl;
      end
      if (rx_cnt == `DSC_RX_OVER) begin
        ovr_tgl <= ~ovr_tgl;
      end
    end
  end

  // Output bit index advances on rising edge; host keeps clock low at select edges
  always_ff @(posedge sclk_i or negedge rx_rst_n) begin
    if (!rx_rst_n) begin
      tx_cnt <= 3'h0;
    end else begin
      tx_cnt <= tx_cnt + 3'h1;
    end
  end

  // Serial out: snapshot bit, MSB first, driven only while selected
  assign so_o    = shadow[`DSC_TX_MSB - tx_cnt];
  assign so_oe_o = ~cs_n_i & spi_mode;

  // ****************************************
  // Crossings into the core domain
  // ****************************************
  logic [3:0]  cs_sync;
  logic [2:0]  frm_s;
  logic [2:0]  ovr_s;
  logic [11:0] pin_s1;
  logic [11:0] pin_s2;
  wire  [11:0] pin_raw = {parallel_in_ch2_i, parallel_in_ch1_i, uv_rst_i, short_gnd_i,
                          open_load_i, overload_i, ch_overtemp_i, ic_overtemp_i};

  // Select level, frame toggles and pins each pass two flip-flops
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_sync <= `DSC_CS_SYNC_RST;
      frm_s   <= 3'h0;
      ovr_s   <= 3'h0;
      pin_s1  <= 12'h000;
      pin_s2  <= 12'h000;
    end else begin
      cs_sync <= {cs_sync[2:0], cs_n_i};
      frm_s   <= {frm_s[1:0], frm_tgl};
      ovr_s   <= {ovr_s[1:0], ovr_tgl};
      pin_s1  <= pin_raw;
      pin_s2  <= pin_s1;
    end
  end

  wire [1:0] par_on  = pin_s2[11:10];
  wire       uv_s    = pin_s2[9];
  wire [1:0] short_s = pin_s2[8:7];
  wire [1:0] open_s  = pin_s2[6:5];
  wire [1:0] ovl_s   = pin_s2[4:3];
  wire [1:0] ot_s    = pin_s2[2:1];
  wire       icot_s  = pin_s2[0];
  wire       frm_evt = frm_s[1] ^ frm_s[2];
  wire       ovr_evt = ovr_s[1] ^ ovr_s[2];
  wire       cs_idle = cs_sync[1];
  // Commit one cycle behind the select rise so frame toggles have landed
  wire       commit  = cs_sync[2] & ~cs_sync[3];

  // ****************************************
  // Command decode
  // ****************************************
  logic       frm_seen;
  logic       ovr_seen;
  dsc_mode_t  mode;
  dsc_mode_t  next_mode;

  // Frame completion flags, cleared once the frame is committed
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frm_seen <= 1'b0;
      ovr_seen <= 1'b0;
    end else begin
      frm_seen <= frm_evt | (frm_seen & ~commit);
      ovr_seen <= ovr_evt | (ovr_seen & ~commit);
    end
  end

  wire [2:0] cmd      = frame_word[`DSC_CMD_HI:`DSC_CMD_LO];
  wire [4:0] dat      = frame_word[`DSC_CMD_LO-1:0];
  wire       in_sleep = (mode == mode_sleep);
  wire       frame_ok = frm_seen & ~ovr_seen;
  wire       cmd_ok   = frame_ok & (cmd != `DSC_CMD_NOP)
                        & (~in_sleep | (cmd == `DSC_CMD_WAKE));
  wire       take     = commit & cmd_ok;
  wire       ld_out   = take & (cmd == `DSC_CMD_OUTCFG);
  wire       ld_io    = take & (cmd == `DSC_CMD_IOCFG);
  wire       ld_on    = take & (cmd == `DSC_CMD_CHON);
  wire       do_reset = (take & (cmd == `DSC_CMD_RESET)) | uv_s;
  wire       do_sleep = take & (cmd == `DSC_CMD_SLEEP);
  wire       do_wake  = (take & (cmd == `DSC_CMD_WAKE) & in_sleep) | (in_sleep & uv_s);
  wire       diag_clr = take | do_reset;

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [1:0] ovl_mode;
  logic       ot_latch;
  logic [1:0] slew;
  logic [1:0] src;
  logic [1:0] mf;
  logic [1:0] ser_on;

  // Loads per command; reset command or undervoltage restores defaults
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      {ovl_mode, ot_latch, slew, spi_mode, src, mf, ser_on} <= 12'h000;
    end else if (do_reset) begin
      {ovl_mode, ot_latch, slew, spi_mode, src, mf, ser_on} <= 12'h000;
    end else begin
      if (ld_out) begin
        ovl_mode <= {dat[`DSC_D_OVL2], dat[`DSC_D_OVL1]};
        ot_latch <= dat[`DSC_D_OTLATCH];
        slew     <= {dat[`DSC_D_SLEW2], dat[`DSC_D_SLEW1]};
      end
      if (ld_io) begin
        spi_mode <= dat[`DSC_D_IOSPI];
        src      <= dat[`DSC_D_SRC_HI:`DSC_D_SRC_LO];
        mf       <= dat[`DSC_D_MF_HI:`DSC_D_MF_LO];
      end
      if (ld_on) begin
        ser_on <= {dat[`DSC_D_CH2], dat[`DSC_D_CH1]};
      end else if (do_sleep) begin
        ser_on <= 2'h0;
      end
    end
  end

  assign overload_mode_ch1_o = ovl_mode[0];
  assign overload_mode_ch2_o = ovl_mode[1];
  assign ot_latch_o          = ot_latch;
  assign slow_slew_o         = slew;
  assign spi_diag_mode_o     = spi_mode;
  assign ctrl_src_o          = src;
  assign mf_sel_o            = mf;
  wire [11:0] cfg_vec = {ovl_mode, ot_latch, slew, spi_mode, src, mf, ser_on};

  // ****************************************
  // Power mode and wake settling
  // ****************************************
  logic [WAKE_W-1:0] wake_cnt;
  wire               wake_done = (wake_cnt == WAKE_W'(WAKE_CYC - 1));

  // Mode transitions
  always_comb begin
    next_mode = mode;
    case (mode)
      mode_active: begin
        if (do_sleep) begin
          next_mode = mode_sleep;
        end
      end
      mode_sleep: begin
        if (do_wake) begin
          next_mode = mode_waking;
        end
      end
      mode_waking: begin
        if (do_sleep) begin
          next_mode = mode_sleep;
        end else if (wake_done) begin
          next_mode = mode_active;
        end
      end
      default: begin
        next_mode = mode_active;
      end
    endcase
  end

  // Mode register and settle counter
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode     <= mode_active;
      wake_cnt <= '0;
    end else begin
      mode     <= next_mode;
      wake_cnt <= (mode == mode_waking) ? wake_cnt + WAKE_W'(1) : '0;
    end
  end

  assign mode_o  = mode;
  assign ready_o = (mode == mode_active);

  // ****************************************
  // Channel control
  // ****************************************
  logic [1:0] ch_on;
  wire  [1:0] ctl = (src == `DSC_SRC_PAR) ? par_on :
                    (src == `DSC_SRC_OR)  ? (par_on | ser_on) :
                    (src == `DSC_SRC_AND) ? (par_on & ser_on) : ser_on;

  // Outputs held off outside active mode
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ch_on <= 2'h0;
    end else begin
      ch_on <= ready_o ? ctl : 2'h0;
    end
  end

  assign ch_on_o = ch_on;

  // ****************************************
  // Diagnosis register
  // ****************************************
  logic [1:0] code [2];
  logic [1:0] otf;
  logic       icw;
  logic [1:0] lat;

  // Per channel fault filter and two-bit code
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic [FILT_W-1:0] filt_cnt;
    wire raw_any  = short_s[c] | open_s[c] | ovl_s[c];
    wire filt_hit = ready_o & raw_any & (filt_cnt == FILT_W'(FILT_CYC - 1));
    wire ot_hit   = ready_o & ot_s[c] & ch_on[c];
    wire [1:0] new_code = ot_hit      ? `DSC_CODE_OVL :
                          short_s[c]  ? `DSC_CODE_SHORT :
                          open_s[c]   ? `DSC_CODE_OPEN : `DSC_CODE_OVL;
    assign lat[c] = filt_hit | ot_hit;

    // Filter restarts on clear or when the fault drops; a latch beats a clear
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        filt_cnt <= '0;
        code[c]  <= `DSC_CODE_OK;
        otf[c]   <= 1'b0;
      end else begin
        if (diag_clr | ~raw_any | ~ready_o) begin
          filt_cnt <= '0;
        end else if (filt_cnt != FILT_W'(FILT_CYC)) begin
          filt_cnt <= filt_cnt + FILT_W'(1);
        end
        if (lat[c]) begin
          code[c] <= new_code;
        end else if (diag_clr) begin
          code[c] <= `DSC_CODE_OK;
        end
        if (ot_hit) begin
          otf[c] <= 1'b1;
        end else if (diag_clr) begin
          otf[c] <= 1'b0;
        end
      end
    end
  end

  wire [7:0] diag_word = {`DSC_DIAG_UNUSED, code[1], code[0], |otf, icw};

  // IC warning flag and serial snapshot refreshed while deselected and awake
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      icw    <= 1'b0;
      shadow <= `DSC_DIAG_RST;
    end else begin
      icw <= (ready_o & icot_s) | (icw & ~diag_clr);
      if (cs_idle & ~in_sleep) begin
        shadow <= diag_word;
      end
    end
  end

  wire       fault_any = (code[0] != `DSC_CODE_OK) | (code[1] != `DSC_CODE_OK) | (|otf) | icw;
  assign fault_flag_n_o       = ~fault_any;
  assign sense_fault_pin_oe_o = spi_mode & (mf == `DSC_MF_FAULT) & fault_any;

  // ****************************************
  // Assertions
  // ****************************************
  so_release_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    (cs_n_i | ~spi_mode) |-> !so_oe_o) else $error("Serial out driven while deselected");
  snap_hold_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    !cs_sync[1] |=> $stable(shadow)) else $error("Snapshot changed during frame");
  bits_high_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    shadow[7:6] == `DSC_DIAG_UNUSED) else $error("Unused diagnosis bits not high");
  clear_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    take && !lat[0] && !lat[1] |=> code[0] == `DSC_CODE_OK && code[1] == `DSC_CODE_OK && otf == 2'h0)
    else $error("Diagnosis not cleared after valid frame");
  inval_keep_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    commit && !cmd_ok && !uv_s && !lat[0] |=> $stable(cfg_vec) && $stable(code[0]))
    else $error("Invalid frame changed state");
  nop_keep_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    commit && frame_ok && cmd == `DSC_CMD_NOP && !uv_s && mode != mode_waking |=> $stable(cfg_vec) && $stable(mode))
    else $error("No command changed state");
  rd_keep_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    take && cmd == `DSC_CMD_DIAG && !uv_s && mode != mode_waking |=> $stable(cfg_vec) && $stable(mode))
    else $error("Diagnosis read changed configuration");
  sleep_ign_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    commit && in_sleep && cmd != `DSC_CMD_WAKE && !uv_s |=> $stable(cfg_vec) && mode == mode_sleep)
    else $error("Command acted in sleep");
  sleep_off_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    do_sleep |=> ser_on == 2'h0 ##1 ch_on_o == 2'h0) else $error("Outputs not off after sleep");
  outcfg_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ld_out && !do_reset |=> {overload_mode_ch2_o, overload_mode_ch1_o} == $past(dat[4:3]))
    else $error("Overload mode not loaded");
  chon_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    ld_on && !do_reset |=> ser_on == $past(dat[4:3])) else $error("Serial on bits not loaded");
  ot_imm_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    g_ch[0].ot_hit |=> code[0] == `DSC_CODE_OVL && otf[0] && !fault_flag_n_o)
    else $error("Overtemperature not latched at once");
  wake_wait_a: assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
    do_wake |=> !ready_o [*2]) else $error("Ready before wake settling");
endmodule

// ===== dsc_host.sv
// Host serial master model for the dual switch control logic
`timescale 1ns/100ps
module dsc_host (
  output logic      sclk_o,  // Serial clock, idle low
  output logic      cs_n_o,  // Chip select, low active
  output logic      si_o,    // Serial data to device
  input  wire logic so_i     // Serial data from device
);
  // Idle bus: clock low, deselected, input pulled down
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    si_o   = 1'b0;
  end
  // Send n bits MSB first at 12 ns per bit, collect the shifted out bits
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    cs_n_o = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      si_o = tx[7 - i];
      rx[7 - i] = so_i;
      #3 sclk_o = 1'b1;
      #6 sclk_o = 1'b0;
      #3;
    end
    si_o = 1'b0;
    cs_n_o = 1'b1;
  endtask
endmodule

// ===== tb_dual_switch_spi_control_diag.sv
// Self-checking bench of the dual switch serial control and diagnosis logic
`timescale 1ns/100ps
module tb_dual_switch_spi_control_diag;
  import dsc_pkg::*;
  logic core_clk_i, arst_n_i, sclk, cs_n, si, so_o, so_oe_o, par1, par2, uv_rst_i, ic_ot;
  logic ovl1, ovl2, otl, spim, ffn, pin_oe, ready_o;
  logic [1:0] short_gnd, open_load, ch_on_o, slew, src, mf, ovl_in, ch_ot;
  dsc_mode_t mode_o;
  logic [1:0] e_ovl, e_slew, e_src, e_mf, e_son;
  logic e_otl, e_spi, e_slp;
  logic [7:0] e_diag;
  int fails, check_count, cycles;
  logic [2:0] seq[$] = '{3'h2, 3'h3, 3'h7, 3'h1, 3'h0, 3'h4, 3'h7, 3'h5, 3'h2, 3'h3, 3'h6};

  // Released serial out shows the inverse of the mux, so a missing enable is caught
  dsc_host host (.sclk_o(sclk), .cs_n_o(cs_n), .si_o(si), .so_i(so_oe_o ? so_o : ~so_o));
  dsc_spi_diag #(.FILTER_NS(200), .WAKE_NS(200)) DUT (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .si_i(si),
    .so_o(so_o), .so_oe_o(so_oe_o), .parallel_in_ch1_i(par1), .parallel_in_ch2_i(par2),
    .uv_rst_i(uv_rst_i), .short_gnd_i(short_gnd), .open_load_i(open_load), .overload_i(ovl_in),
    .ch_overtemp_i(ch_ot), .ic_overtemp_i(ic_ot), .ch_on_o(ch_on_o), .overload_mode_ch1_o(ovl1),
    .overload_mode_ch2_o(ovl2), .ot_latch_o(otl), .slow_slew_o(slew), .spi_diag_mode_o(spim),
    .ctrl_src_o(src), .mf_sel_o(mf), .fault_flag_n_o(ffn), .sense_fault_pin_oe_o(pin_oe),
    .mode_o(mode_o), .ready_o(ready_o));

  // Core clock 40 ns and hang guard
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Reference model of the command decoder
  task automatic model(input logic [7:0] f);
    if (e_slp) begin
      if (f[7:5] == 3'h6) begin
        e_slp = 1'b0;
        e_diag = 8'hFC;
      end
    end else begin
      if (f[7:5] != 3'h0) e_diag = 8'hFC;
      case (f[7:5])
        3'h2: {e_ovl, e_otl, e_slew} = f[4:0];
        3'h3: {e_spi, e_src, e_mf} = f[4:0];
        3'h4: {e_ovl, e_otl, e_slew, e_spi, e_src, e_mf, e_son} = 12'h000;
        3'h5: begin
          e_slp = 1'b1;
          e_son = 2'h0;
        end
        3'h7: e_son = f[4:3];
        default: ;
      endcase
    end
  endtask

  // Compare every port result except serial data out with the model
  task automatic check_all;
    logic [1:0] p, eon;
    p = {par2, par1};
    eon = e_slp ? 2'h0 : (e_src == 2'h0) ? p : (e_src == 2'h1) ? (p | e_son) : (e_src == 2'h2) ? (p & e_son) : e_son;
    chk("ch_on", ch_on_o, eon);
    chk("overload_mode", {ovl2, ovl1}, e_ovl);
    chk("ot_latch", otl, e_otl);
    chk("slew", slew, e_slew);
    chk("spi_mode", spim, e_spi);
    chk("ctrl_src", src, e_src);
    chk("mf_sel", mf, e_mf);
    chk("mode", mode_o, e_slp ? 3'h2 : 3'h1);
    chk("ready", ready_o, !e_slp);
    chk("fault_flag_n", ffn, e_diag == 8'hFC);
    chk("pin_oe", pin_oe, e_spi & (e_mf == 2'h0) & (e_diag != 8'hFC));
    chk("so_oe", so_oe_o, 1'b0);
  endtask

  task automatic frame(input logic [7:0] f, input int n);
    logic [7:0] rx, exp;
    logic vis;
    @(negedge core_clk_i);
    {par2, par1} = 2'($urandom);
    exp = e_diag;
    vis = e_spi & !e_slp;
    host.xfer(f, n, rx);
    if (n == 8) model(f);
    repeat (16) @(negedge core_clk_i);
    if (n == 8 && vis) chk("so_data", rx, exp);
    check_all();
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence: reset, command sweep, diagnosis, undervoltage
  initial begin
    {core_clk_i, arst_n_i, par1, par2, uv_rst_i, ic_ot, short_gnd, open_load, ovl_in, ch_ot} = 14'h0000;
    {e_ovl, e_otl, e_slew, e_spi, e_src, e_mf, e_son, e_slp} = 13'h0000;
    e_diag = 8'hFC;
    void'($urandom(32'h4C31));
    repeat (2) @(negedge core_clk_i);
    arst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    check_all();
    repeat (3) foreach (seq[i]) frame({seq[i], 5'($urandom)}, 8);
    $display("test command sweep done");
    frame(8'h70, 8);
    {short_gnd, open_load, ic_ot} = 5'h0D;
    repeat (20) @(negedge core_clk_i);
    {short_gnd, open_load, ic_ot} = 5'h00;
    e_diag = 8'hD1;
    repeat (8) @(negedge core_clk_i);
    check_all();
    frame(8'h00, 8);
    frame(8'h20, 7);
    frame(8'h20, 8);
    frame(8'h20, 8);
    // Channel 1 on and overheating, channel 2 in current limit
    {par2, par1} = 2'h1;
    repeat (4) @(negedge core_clk_i);
    {ovl_in, ch_ot} = 4'h9;
    repeat (20) @(negedge core_clk_i);
    {ovl_in, ch_ot} = 4'h0;
    e_diag = 8'hEA;
    repeat (8) @(negedge core_clk_i);
    check_all();
    frame(8'h20, 8);
    $display("test diagnosis done");
    frame(8'hA0, 8);
    uv_rst_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    uv_rst_i = 1'b0;
    e_slp = 1'b0;
    model(8'h80);
    repeat (16) @(negedge core_clk_i);
    check_all();
    $display("test undervoltage done");
    end_of_test();
  end
endmodule
